// ===== src/ppc_host.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_host
   import ppc_pkg::*;
(
   input wire logic sysClk,          // System clock
   input wire logic sysRst,          // Async reset, active high
   ppc_link_if.host link,            // Configuration link
   input wire logic [11:0] paddr,    // APB address
   input wire logic psel,            // APB select
   input wire logic penable,         // APB enable
   input wire logic pwrite,          // APB direction
   input wire logic [31:0] pwdata,   // APB write data
   output logic [31:0] prdata,       // APB read data
   output logic pready,              // APB ready
   output logic pslverr,             // APB error
   output logic irq                  // Level interrupt
);
`include "ppc_map.svh"
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] stSync, dnSync;
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         stSync <= 3'h0;
         dnSync <= 3'h0;
      end
      else
      begin
         stSync <= {stSync[1:0], link.statusN};
         dnSync <= {dnSync[1:0], link.doneLine};
      end
   end
   wire stHigh = stSync[1] & stSync[2];
   wire dnHigh = dnSync[1] & dnSync[2];
   // ----------------------------------------
   // Registers and sequencer
   // ----------------------------------------
   ppc_host_e st_reg, st_next;
   logic [15:0] ctrl_reg, ctrl_next;
   logic [15:0] data_reg, data_next;
   logic full_reg, full_next;
   logic [2:0] irqSt_reg, irqSt_next;
   logic [2:0] irqEn_reg, irqEn_next;
   logic [7:0] div_reg, div_next;
   logic [2:0] rep_reg, rep_next;
   logic [1:0] tail_reg, tail_next;
   logic [15:0] pin_reg, pin_next;
   logic clk_reg, clk_next;
   logic req_reg, req_next;
   logic [31:0] rd;
   logic [2:0] ev;
   logic [2:0] ratio;
   wire wr = psel & penable & pwrite;
   wire [7:0] half = ctrl_reg[`PPC_CTRL_DIVHI:`PPC_CTRL_DIVLO];
   always_comb
   begin
      ratio = ppc_ratio(ctrl_reg[`PPC_CTRL_WIDE], ctrl_reg[`PPC_CTRL_COMP],
                        ctrl_reg[`PPC_CTRL_SEC]);
      st_next = st_reg;
      ctrl_next = ctrl_reg;
      data_next = data_reg;
      full_next = full_reg;
      irqEn_next = irqEn_reg;
      div_next = (div_reg == 8'h0) ? 8'h0 : div_reg - 8'h1;
      rep_next = rep_reg;
      tail_next = tail_reg;
      pin_next = pin_reg;
      clk_next = clk_reg;
      req_next = req_reg;
      ev = 3'h0;
      if (wr && paddr == `PPC_OFS_CTRL)
         ctrl_next = pwdata[15:0];
      if (wr && paddr == `PPC_OFS_IRQEN)
         irqEn_next = pwdata[2:0];
      if (wr && paddr == `PPC_OFS_DATA && !full_reg)
      begin
         data_next = pwdata[15:0];
         full_next = 1'b1;
      end
      unique case (st_reg)
         PPC_H_IDLE:
         begin
            clk_next = 1'b0;
            if (wr && paddr == `PPC_OFS_CTRL && pwdata[`PPC_CTRL_START])
            begin
               st_next = PPC_H_REQ;
               req_next = 1'b0;
               div_next = half;
            end
         end
         PPC_H_REQ:
            if (div_reg == 8'h0 && !stHigh)
            begin
               req_next = 1'b1;
               st_next = PPC_H_WAIT;
            end
         PPC_H_WAIT:
            if (stHigh)
            begin
               st_next = PPC_H_LOW;
               rep_next = 3'h0;
            end
         PPC_H_LOW:
            if (dnHigh)
            begin
               st_next = PPC_H_TAIL;
               tail_next = 2'h0;
               div_next = half;
               ev[`PPC_EV_DONE] = 1'b1;
            end
            else if (!stHigh)
            begin
               st_next = PPC_H_IDLE;
               ev[`PPC_EV_ERR] = 1'b1;
            end
            else if (div_reg == 8'h0)
            begin
               // High half over: clock drops, pauses stay low
               clk_next = 1'b0;
               if (rep_reg != 3'h0 || full_reg)
               begin
                  if (rep_reg == 3'h0)
                  begin
                     pin_next = ctrl_reg[`PPC_CTRL_WIDE] ? data_reg
                                                        : {8'h00, data_reg[7:0]};
                     full_next = 1'b0;
                  end
                  st_next = PPC_H_HIGH;
                  div_next = half;
               end
            end
         PPC_H_HIGH:
            if (div_reg == 8'h0)
            begin
               clk_next = 1'b1;
               st_next = PPC_H_LOW;
               div_next = half;
               rep_next = (rep_reg == ratio - 3'h1) ? 3'h0 : rep_reg + 3'h1;
            end
            else
               clk_next = 1'b0;
         PPC_H_TAIL:
            if (div_reg == 8'h0)
            begin
               clk_next = ~clk_reg;
               div_next = half;
               if (clk_reg)
               begin
                  tail_next = tail_reg + 2'h1;
                  if (tail_reg == 2'(`PPC_INIT_EDGES - 1))
                  begin
                     st_next = PPC_H_IDLE;
                     ev[`PPC_EV_USER] = 1'b1;
                  end
               end
            end
         default:
            st_next = PPC_H_IDLE;
      endcase
      irqSt_next = irqSt_reg | ev;
      if (wr && paddr == `PPC_OFS_IRQCLR)
         irqSt_next = (irqSt_reg & ~pwdata[2:0]) | ev;
   end
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         st_reg <= PPC_H_IDLE;
         ctrl_reg <= {`PPC_DIV_RST, 8'h00};
         data_reg <= 16'h0000;
         full_reg <= 1'b0;
         irqSt_reg <= 3'h0;
         irqEn_reg <= 3'h0;
         div_reg <= 8'h00;
         rep_reg <= 3'h0;
         tail_reg <= 2'h0;
         pin_reg <= 16'h0000;
         clk_reg <= 1'b0;
         req_reg <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
         ctrl_reg <= ctrl_next;
         data_reg <= data_next;
         full_reg <= full_next;
         irqSt_reg <= irqSt_next;
         irqEn_reg <= irqEn_next;
         div_reg <= div_next;
         rep_reg <= rep_next;
         tail_reg <= tail_next;
         pin_reg <= pin_next;
         clk_reg <= clk_next;
         req_reg <= req_next;
      end
   end
   // ----------------------------------------
   // APB read mux and outputs
   // ----------------------------------------
   always_comb
   begin
      rd = 32'h0;
      pslverr = 1'b0;
      unique case (paddr)
         `PPC_OFS_CTRL: rd = {16'h0, ctrl_reg & 16'hff0e};
         `PPC_OFS_STAT: rd = {27'h0, ~full_reg, stHigh && st_reg == PPC_H_IDLE && dnHigh,
                              dnHigh, stHigh, st_reg != PPC_H_IDLE};
         `PPC_OFS_DATA: rd = {16'h0, data_reg};
         `PPC_OFS_IRQST: rd = {29'h0, irqSt_reg};
         `PPC_OFS_IRQCLR: rd = 32'h0;
         `PPC_OFS_IRQEN: rd = {29'h0, irqEn_reg};
         default: pslverr = psel & penable;
      endcase
      prdata = rd;
   end
   assign pready = 1'b1;
   assign irq = |(irqSt_reg & irqEn_reg);
   assign link.reqN = req_reg;
   assign link.cfgBitClock = clk_reg;
   assign link.data = pin_reg;
endmodule
`default_nettype wire

// ===== pkg/ppc_map.svh
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH
// ----------------------------------------
// Host register offsets (APB byte addresses)
// ----------------------------------------
`define PPC_OFS_CTRL 12'h000
`define PPC_OFS_STAT 12'h004
`define PPC_OFS_DATA 12'h008
`define PPC_OFS_IRQST 12'h00c
`define PPC_OFS_IRQCLR 12'h010
`define PPC_OFS_IRQEN 12'h014
// ----------------------------------------
// Control fields
// ----------------------------------------
`define PPC_CTRL_START 0
`define PPC_CTRL_WIDE 1
`define PPC_CTRL_COMP 2
`define PPC_CTRL_SEC 3
`define PPC_CTRL_DIVLO 8
`define PPC_CTRL_DIVHI 15
// ----------------------------------------
// Status and interrupt fields
// ----------------------------------------
`define PPC_ST_BUSY 0
`define PPC_ST_STATUSN 1
`define PPC_ST_DONE 2
`define PPC_ST_INITDONE 3
`define PPC_ST_WREADY 4
`define PPC_EV_DONE 0
`define PPC_EV_USER 1
`define PPC_EV_ERR 2
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PPC_DIV_RST 8'h04
`define PPC_POR_NS 1000
`define PPC_CLK_NS 10
`define PPC_POR_CYC ((`PPC_POR_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_INIT_EDGES 2
`endif

// ===== pkg/ppc_pkg.sv
package ppc_pkg;
   typedef enum logic [2:0]
   {
      PPC_D_POR = 3'b000,
      PPC_D_CLEAR = 3'b001,
      PPC_D_LOAD = 3'b010,
      PPC_D_INIT = 3'b011,
      PPC_D_USER = 3'b100
   } ppc_dev_e;
   typedef enum logic [2:0]
   {
      PPC_H_IDLE = 3'b000,
      PPC_H_REQ = 3'b001,
      PPC_H_WAIT = 3'b010,
      PPC_H_LOW = 3'b011,
      PPC_H_HIGH = 3'b100,
      PPC_H_TAIL = 3'b101
   } ppc_host_e;
   // Clock-to-data ratio for bus width and options
   function automatic logic [2:0] ppc_ratio(input logic wide, input logic comp,
                                          input logic sec);
      if (!wide)
         ppc_ratio = comp ? 3'h2 : 3'h1;
      else if (comp)
         ppc_ratio = 3'h4;
      else
         ppc_ratio = sec ? 3'h2 : 3'h1;
   endfunction
endpackage

// ===== pkg/ppc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ppc_link_if;
   logic reqN;
   logic statusNOut;
   logic statusNOe;
   logic doneOut;
   logic doneOe;
   logic initDoneOut;
   logic initDoneOe;
   logic cfgBitClock;
   logic [15:0] data;
   wire statusN = statusNOe ? 1'b1 : statusNOut;
   wire doneLine = doneOe ? 1'b1 : doneOut;
   modport dev (input reqN, cfgBitClock, data, statusN, doneLine,
                output statusNOut, statusNOe, doneOut, doneOe, initDoneOut, initDoneOe);
   modport host (output reqN, cfgBitClock, data, input statusN, doneLine);
endinterface
`default_nettype wire

// ===== src/ppc_device.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Request low restarts configuration anytime after the power-on delay
// - User mode: request, status, done high
// - Status held low for power-on delay
// - Done low until load finishes
// - Ratio from width, compression, security
// - Host drives 16 or 8 data bits
// - Host sends whole image
// - Done rises only after error-free load
// - Host gives two falling edges after done
// - Clock ignored after configuration
// - Host pauses only with clock low
// - Init-done pin low only during initialization
module ppc_device
   import ppc_pkg::*;
#(
   parameter int IMAGE_WORDS = 16,
   parameter int POR_CYCLES = `PPC_POR_CYC
)
(
   input wire logic sysClk,          // System clock
   input wire logic sysRst,          // Async reset, active high
   ppc_link_if.dev link,             // Configuration link
   input wire logic wideMode,        // 16-bit scheme strap
   input wire logic compEn,          // Decompression option
   input wire logic secEn,           // Security option
   input wire logic initDoneOptEn,   // Init-done pin option
   output logic [15:0] imageWord,    // Last received word
   output logic imageWordValid,      // Pulse per word
   output logic userMode,            // In user mode
   output logic loadError            // Restart request seen during load
);
`include "ppc_map.svh"
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [2:0] clkSync, reqSync;
   logic [15:0] dS1, dS2, dS3;
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         clkSync <= 3'h0;
         reqSync <= 3'h7;
         dS1 <= 16'h0000;
         dS2 <= 16'h0000;
         dS3 <= 16'h0000;
      end
      else
      begin
         clkSync <= {clkSync[1:0], link.cfgBitClock};
         reqSync <= {reqSync[1:0], link.reqN};
         dS1 <= link.data;
         dS2 <= dS1;
         dS3 <= dS2;
      end
   end
   wire clkRise = clkSync[1] & ~clkSync[2];
   wire clkFall = ~clkSync[1] & clkSync[2];
   wire reqLow = ~reqSync[1] & ~reqSync[2];
   // ----------------------------------------
   // Configuration sequencer
   // ----------------------------------------
   ppc_dev_e state_reg, state_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [2:0] sub_reg, sub_next;
   logic [1:0] edge_reg, edge_next;
   logic err_reg, err_next;
   logic initOpt_reg, initOpt_next;
   logic [15:0] word_reg, word_next;
   logic valid_reg, valid_next;
   logic [2:0] ratio;
   always_comb
   begin
      ratio = ppc_ratio(wideMode, compEn, secEn);
      state_next = state_reg;
      cnt_next = cnt_reg;
      sub_next = sub_reg;
      edge_next = edge_reg;
      err_next = err_reg;
      initOpt_next = initOpt_reg;
      word_next = word_reg;
      valid_next = 1'b0;
      unique case (state_reg)
         PPC_D_POR:
         begin
            if (cnt_reg >= 32'(POR_CYCLES - 1))
            begin
               state_next = PPC_D_CLEAR;
               cnt_next = 32'h0;
            end
            else
               cnt_next = cnt_reg + 32'h1;
         end
         PPC_D_CLEAR:
         begin
            if (!reqLow)
            begin
               state_next = PPC_D_LOAD;
               cnt_next = 32'h0;
               sub_next = 3'h0;
               err_next = 1'b0;
               initOpt_next = initDoneOptEn;
            end
         end
         PPC_D_LOAD:
         begin
            if (clkRise)
            begin
               if (sub_reg == ratio - 3'h1)
               begin
                  sub_next = 3'h0;
                  word_next = wideMode ? dS3 : {8'h00, dS3[7:0]};
                  valid_next = 1'b1;
                  if (cnt_reg == 32'(IMAGE_WORDS - 1))
                  begin
                     state_next = PPC_D_INIT;
                     edge_next = 2'h0;
                  end
                  cnt_next = cnt_reg + 32'h1;
               end
               else
                  sub_next = sub_reg + 3'h1;
            end
         end
         PPC_D_INIT:
         begin
            if (clkFall)
            begin
               if (edge_reg == 2'(`PPC_INIT_EDGES - 1))
                  state_next = PPC_D_USER;
               edge_next = edge_reg + 2'h1;
            end
         end
         PPC_D_USER:
            ;
      endcase
      if (reqLow && state_reg != PPC_D_POR)
      begin
         state_next = PPC_D_CLEAR;
         if (state_reg == PPC_D_LOAD)
            err_next = 1'b1;
      end
   end
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         state_reg <= PPC_D_POR;
         cnt_reg <= 32'h0;
         sub_reg <= 3'h0;
         edge_reg <= 2'h0;
         err_reg <= 1'b0;
         initOpt_reg <= 1'b0;
         word_reg <= 16'h0000;
         valid_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sub_reg <= sub_next;
         edge_reg <= edge_next;
         err_reg <= err_next;
         initOpt_reg <= initOpt_next;
         word_reg <= word_next;
         valid_reg <= valid_next;
      end
   end
   // ----------------------------------------
   // Pin drivers, enable low drives low
   // ----------------------------------------
   wire inCfg = state_reg == PPC_D_POR || state_reg == PPC_D_CLEAR;
   wire loaded = state_reg == PPC_D_INIT || state_reg == PPC_D_USER;
   assign link.statusNOut = 1'b0;
   assign link.statusNOe = ~inCfg;
   assign link.doneOut = 1'b0;
   assign link.doneOe = loaded;
   assign link.initDoneOut = 1'b0;
   assign link.initDoneOe = ~(initOpt_reg && state_reg == PPC_D_INIT);
   assign imageWord = word_reg;
   assign imageWordValid = valid_reg;
   assign userMode = state_reg == PPC_D_USER;
   assign loadError = err_reg;
endmodule
`default_nettype wire

// ===== tb/ppc_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_link_asserts
#(
   parameter int IMAGE_WORDS = 16,
   parameter int POR_CYCLES = 100
)
(
   input wire logic sysClk,       // Clock
   input wire logic sysRst,       // Reset
   input wire logic reqN,         // Restart request
   input wire logic initDoneOut,  // Init-done value
   input wire logic initDoneOe,   // Init-done enable
   input wire logic cfgBitClock,  // Link clock
   input wire logic statusN,      // Status line
   input wire logic doneLine      // Done line
);
   // ----
   // Edge and cycle counters
   // ----
   int porCnt_reg, porCnt_next, edgeCnt_reg, edgeCnt_next, fallCnt_reg, fallCnt_next;
   logic clkQ_reg, clkQ_next;
   always_comb
   begin
      porCnt_next = (porCnt_reg < POR_CYCLES) ? porCnt_reg + 1 : porCnt_reg;
      clkQ_next = cfgBitClock;
      edgeCnt_next = edgeCnt_reg;
      fallCnt_next = fallCnt_reg;
      if (!statusN)
         edgeCnt_next = 0;
      else if (cfgBitClock && !clkQ_reg && !doneLine)
         edgeCnt_next = edgeCnt_reg + 1;
      if (!doneLine)
         fallCnt_next = 0;
      else if (!cfgBitClock && clkQ_reg && fallCnt_reg < 7)
         fallCnt_next = fallCnt_reg + 1;
   end
   always_ff @(posedge sysClk or posedge sysRst)
   begin
      if (sysRst)
      begin
         porCnt_reg <= 0;
         edgeCnt_reg <= 0;
         fallCnt_reg <= 0;
         clkQ_reg <= 1'b0;
      end
      else
      begin
         porCnt_reg <= porCnt_next;
         edgeCnt_reg <= edgeCnt_next;
         fallCnt_reg <= fallCnt_next;
         clkQ_reg <= clkQ_next;
      end
   end
   // ----
   // Properties
   // ----
   default clocking cb @(posedge sysClk);
   endclocking
   default disable iff (sysRst);
   por_hold_a: assert property (porCnt_reg < POR_CYCLES - 1 |-> !statusN)
      else $error("status released early");
   done_clear_a: assert property ($fell(statusN) |-> ##[0:3] !doneLine)
      else $error("done high in clear");
   done_rise_a: assert property ($rose(doneLine) |-> edgeCnt_reg >= IMAGE_WORDS)
      else $error("done before image end");
   user_high_a: assert property (doneLine && reqN && $past(reqN) |-> statusN)
      else $error("status low in user mode");
   restart_a: assert property ($fell(reqN) |-> ##[1:8] !statusN)
      else $error("no restart on request");
   init_when_a: assert property (!initDoneOe |-> doneLine && !initDoneOut && fallCnt_reg <= 2)
      else $error("init pin low out of place");
   done_hold_a: assert property (doneLine && reqN && $past(reqN) |=> doneLine)
      else $error("done dropped by clock");
   tail_edges_a: assert property ($rose(doneLine) |-> ##[1:300] fallCnt_reg == 2)
      else $error("tail edges missing");
   init_release_a: assert property (fallCnt_reg == 2 |-> ##[0:8] initDoneOe)
      else $error("init pin not released");
   cover property ($rose(doneLine));
   cover property ($fell(statusN) && doneLine);
   cover property ($fell(initDoneOe));
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
$display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb
   import ppc_pkg::*;
;
   localparam int NW = 4;
   logic sysClk = 1'b0;
   logic sysRst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clkQ = 1'b0, sawInit = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hce3e;
   logic pready, pslverr, irq, err, userMode, loadError, imageWordValid;
   logic wideMode = 1'b0, compEn = 1'b0, secEn = 1'b0, initDoneOptEn = 1'b0;
   logic [15:0] imageWord, expW, mask = 16'hffff;
   logic [15:0] expQ[$];
   int n_fail = 0, num_checks = 0, cyc = 0, edges = 0, ratio = 1, n;
   ppc_link_if lnk();
   wire initDoneLine = lnk.initDoneOe ? 1'b1 : lnk.initDoneOut;
   ppc_device #(.IMAGE_WORDS(NW), .POR_CYCLES(20)) i_ppc_device
   (
      .sysClk(sysClk), .sysRst(sysRst), .link(lnk), .wideMode(wideMode), .compEn(compEn),
      .secEn(secEn), .initDoneOptEn(initDoneOptEn), .imageWord(imageWord),
      .imageWordValid(imageWordValid), .userMode(userMode), .loadError(loadError)
   );
   ppc_host i_ppc_host
   (
      .sysClk(sysClk), .sysRst(sysRst), .link(lnk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq)
   );
   ppc_link_asserts #(.IMAGE_WORDS(NW), .POR_CYCLES(20)) i_ppc_link_asserts
   (
      .sysClk(sysClk), .sysRst(sysRst), .reqN(lnk.reqN), .initDoneOut(lnk.initDoneOut),
      .initDoneOe(lnk.initDoneOe), .cfgBitClock(lnk.cfgBitClock), .statusN(lnk.statusN),
      .doneLine(lnk.doneLine)
   );
   // ----
   // Clock, reset, bus tasks
   // ----
   initial forever #5 sysClk = ~sysClk;
   initial
   begin
      repeat (5) @(posedge sysClk);
      sysRst <= 1'b0;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      xs = x ^ (x << 5);
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge sysClk);
      penable <= 1'b1;
      do
         @(posedge sysClk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sysClk);
   endtask
   task automatic poll(input int b);
      do
         apb(1'b0, `PPC_OFS_STAT, 32'h0);
      while (rd[b] !== 1'b1);
      // Let the device's synchronised view catch up
      repeat (4) @(posedge sysClk);
   endtask
   task automatic start(input logic [3:0] m);
      wideMode <= m[2];
      compEn <= m[1];
      secEn <= m[0];
      initDoneOptEn <= m[3];
      ratio = !m[2] ? (m[1] ? 2 : 1) : (m[1] ? 4 : (m[0] ? 2 : 1));
      mask = m[2] ? 16'hffff : 16'h00ff;
      apb(1'b1, `PPC_OFS_CTRL, {16'h0, `PPC_DIV_RST, 4'h0, m[0], m[1], m[2], 1'b1});
   endtask
   task automatic send(input int cnt);
      repeat (cnt)
      begin
         poll(`PPC_ST_WREADY);
         seed = xs(seed);
         expQ.push_back(seed[15:0]);
         apb(1'b1, `PPC_OFS_DATA, {16'h0, seed[15:0]});
      end
   endtask
   // ----
   // Word monitor and timeout
   // ----
   always @(posedge sysClk)
   begin
      cyc <= cyc + 1;
      clkQ <= lnk.cfgBitClock;
      if (initDoneLine === 1'b0)
         sawInit <= 1'b1;
      if (lnk.reqN === 1'b0)
      begin
         edges <= 0;
         sawInit <= 1'b0;
      end
      else if (lnk.cfgBitClock && !clkQ)
         edges <= edges + 1;
      if (imageWordValid === 1'b1)
      begin
         expW = expQ.pop_front();
         `CHK(imageWord & mask, expW & mask)
         `CHK(edges, ratio)
         edges <= 0;
      end
      if (cyc == 20000)
      begin
         n_fail++;
         $display("BAD %0t timeout", $time);
         complete_run();
      end
   end
   // ----
   // Scenarios
   // ----
   initial
   begin
      @(negedge sysRst);
      @(posedge sysClk);
      apb(1'b0, `PPC_OFS_STAT, 32'h0);
      `CHK({rd[`PPC_ST_STATUSN], lnk.doneLine}, 2'b00)
      apb(1'b0, 12'h020, 32'h0);
      `CHK(err, 1'b1)
      apb(1'b1, `PPC_OFS_IRQEN, 32'h7);
      for (int m = 0; m < 8; m++)
      begin
         start({m[0] ^ m[1], m[2:0]});
         send(NW);
         poll(`PPC_ST_INITDONE);
         `CHK(rd[`PPC_ST_INITDONE], 1'b1)
         `CHK({userMode, lnk.statusN, lnk.doneLine, lnk.reqN}, 4'hf)
         `CHK(sawInit, m[0] ^ m[1])
         apb(1'b0, `PPC_OFS_IRQST, 32'h0);
         `CHK({irq, rd[2:0]}, 4'hb)
         `CHK(loadError, 1'b0)
         apb(1'b1, `PPC_OFS_IRQCLR, 32'h7);
         `CHK(irq, 1'b0)
         $display("mode %0d done", m);
      end
      apb(1'b1, `PPC_OFS_IRQEN, 32'h0);
      start(4'h4);
      send(2);
      n = 0;
      while (expQ.size() > 0 && n < 500)
      begin
         @(posedge sysClk);
         n++;
      end
      `CHK(expQ.size(), 0)
      apb(1'b0, `PPC_OFS_STAT, 32'h0);
      `CHK({rd[`PPC_ST_DONE], lnk.doneLine, userMode}, 3'h0)
      send(NW - 2);
      poll(`PPC_ST_INITDONE);
      apb(1'b0, `PPC_OFS_IRQST, 32'h0);
      `CHK({irq, rd[0], userMode}, 3'b011)
      $display("partial and mask test done");
      complete_run();
   end
endmodule
`default_nettype wire
